// ---- rx_correlator_config_bank.sv ----
// Purpose: Config bank for envelope detectors and correlator, with AGC link,
//          channel summation and correlator sleep control
// Assumes: Classic Wishbone slave, 8-bit registers in data bits 7:0
// Notes:   All state frozen while ce_i is low
// Functional notes
// (R01) On-off time constant 1.4/1.0/0.6/0.2 us; separate fast decay bit.
// (R02) On-off threshold 55..25% when time constant zero, else 80..65%.
// (R03) Amplitude time constant 8.4/6.8/4.4/2.4 us; threshold 97% or 95%.
// (R04) AGC link forces equal gain using larger channel result; else independent.
// (R05) ISO-A 106k: collision level from field, or equal to slicer level.
// (R06) BPSK: same bit stops phase correction after first data bytes.
// (R07) Software disables phase correction after start for ISO-B 424/848.
// (R08) Summation bit sums AM and PM before digitizing, else separate.
// (R09) Start length 17/9 pulses, or 33/17 when set; by 106k rate.
// (R10) Fast slicer for ISO-A 106k; long 1.5x reference for BPSK.
// (R11) ISO-A 106k collision level 16/28/41/53 percent.
// (R12) BPSK: upper level bit selects end detect level 100% or 66%.
// (R13) BPSK: lower level bit enables subcarrier end detector.
// (R14) BPSK options apply to ISO-A high rate and all ISO-B rates.
// (R15) Sleep after 18 us without pulse; wake by timer or rx_on.
// (R16) Timer wake takes 18 us, or 42 us for stream V and 212.
// (R17) Software sets stream bit only for 424 kHz subcarrier stream.
// (R18) Reference offset -50/-100 mV, first squelch step -100/-200 mV.
// (R19) Upper six bits of second correlator register read zero.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
`include "rx_corr_map.svh"

module rx_correlator_config_bank
(
  input  wire logic                 mclk_i,      // System clock
  input  wire logic                 nrst_i,      // Sync reset, low active
  input  wire logic                 ce_i,        // Clock enable
  input  wire logic                 wb_cyc_i,    // Bus cycle
  input  wire logic                 wb_stb_i,    // Bus strobe
  input  wire logic                 wb_we_i,     // Write enable
  input  wire logic [7:0]           wb_adr_i,    // Byte address
  input  wire logic [3:0]           wb_sel_i,    // Byte lanes
  input  wire logic [31:0]          wb_dat_i,    // Write data
  output logic      [31:0]          wb_dat_o,    // Read data
  output logic                      wb_ack_o,    // Acknowledge
  input  wire rx_corr_pkg::std_e    std_i,       // Standard in use
  input  wire logic                 rate_106_i,  // Bit rate is 106k
  input  wire logic                 rx_on_i,     // Receiver on
  input  wire logic                 pulse_i,     // Correlator output pulse
  input  wire logic [3:0]           agc_am_i,    // AM channel AGC result
  input  wire logic [3:0]           agc_pm_i,    // PM channel AGC result
  input  wire logic [7:0]           corr_am_i,   // AM correlation sample
  input  wire logic [7:0]           corr_pm_i,   // PM correlation sample
  output rx_corr_pkg::rx_cfg_s      cfg_o,       // Decoded settings
  output logic      [3:0]           gain_am_o,   // Applied AM gain
  output logic      [3:0]           gain_pm_o,   // Applied PM gain
  output logic      [8:0]           dig_a_o,     // Digitizer input A
  output logic      [8:0]           dig_b_o,     // Digitizer input B
  output logic                      sleep_o      // Correlator asleep
);

  // ***************************************************
  // Timing counts
  // ***************************************************
  localparam int IdleCyc  = (`SLEEP_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int ShortCyc = (`WAKE_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int LongCyc  = (`WAKE_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // ***************************************************
  // Storage
  // ***************************************************
  logic [7:0]                env_cfg;
  logic [7:0]                corr_a;
  logic [1:0]                corr_b;
  rx_corr_pkg::sleep_e       state;
  logic [11:0]               cnt;
  logic                      req;
  logic                      wr_lo;
  logic [7:0]                rd_val;
  logic                      bpsk;
  logic                      iso_a106;
  logic [11:0]               wake_last;
  rx_corr_pkg::rx_cfg_s      next_cfg;

  // ***************************************************
  // Decode helpers
  // ***************************************************
  // Address match on word index, used for every register
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx);
  endfunction

  // On-off threshold depends on time constant code
  function automatic logic [6:0] onoff_thd(input logic [1:0] thd, input logic [1:0] tc);
    logic [6:0] v;
    v = 7'h00;
    case ({tc != 2'h0, thd})
      3'h0:    v = 7'd55;
      3'h1:    v = 7'd45;
      3'h2:    v = 7'd35;
      3'h3:    v = 7'd25;
      3'h4:    v = 7'd80;
      3'h5:    v = 7'd75;
      3'h6:    v = 7'd70;
      default: v = 7'd65;
    endcase
    onoff_thd = v;
  endfunction

  // ***************************************************
  // Mode grouping
  // ***************************************************
  // Both high-rate ISO-A and all ISO-B run the BPSK path
  assign bpsk     = (std_i == rx_corr_pkg::STD_A_HBR) || (std_i == rx_corr_pkg::STD_B); // R14
  assign iso_a106 = (std_i == rx_corr_pkg::STD_A_106);
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo    = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  // ***************************************************
  // Register writes
  // ***************************************************
  // Write lands at the edge where the master samples ack high
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      env_cfg <= `RST_ENV_CFG;
      corr_a  <= `RST_CORR_A;
      corr_b  <= `RST_CORR_B;
    end
    else if (ce_i && wr_lo)
    begin
      if (hit(wb_adr_i, `IDX_ENV_CFG))
        env_cfg <= wb_dat_i[7:0];
      if (hit(wb_adr_i, `IDX_CORR_A))
        corr_a <= wb_dat_i[7:0];
      if (hit(wb_adr_i, `IDX_CORR_B))
        corr_b <= wb_dat_i[1:0]; // R19
    end
  end

  // ***************************************************
  // Read mux
  // ***************************************************
  // Unmapped addresses read zero and still get ack
  always_comb
  begin
    rd_val = 8'h00;
    if (hit(wb_adr_i, `IDX_ENV_CFG))
      rd_val = env_cfg;
    else if (hit(wb_adr_i, `IDX_CORR_A))
      rd_val = corr_a;
    else if (hit(wb_adr_i, `IDX_CORR_B))
      rd_val = {6'h00, corr_b}; // R19
    else if (hit(wb_adr_i, `IDX_STATUS))
      rd_val = {gain_am_o[3:0], 2'h0, state};
  end

  // ***************************************************
  // Bus answer
  // ***************************************************
  // One-cycle ack; dropped the cycle after it was given
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= {24'h00_0000, rd_val};
    end
  end

  // ***************************************************
  // Field decode
  // ***************************************************
  always_comb
  begin
    next_cfg = '0;
    case (env_cfg[`B_ONOFF_TC_HI:`B_ONOFF_TC_LO])
      2'h0:    next_cfg.onoff_tc_ns = 11'd1400; // R01
      2'h1:    next_cfg.onoff_tc_ns = 11'd1000; // R01
      2'h2:    next_cfg.onoff_tc_ns = 11'd600; // R01
      default: next_cfg.onoff_tc_ns = 11'd200; // R01
    endcase
    next_cfg.onoff_fast_decay = env_cfg[`B_ONOFF_FD]; // R01
    next_cfg.onoff_thd_pct = onoff_thd(env_cfg[`B_ONOFF_THD_HI:`B_ONOFF_THD_LO],
                                       env_cfg[`B_ONOFF_TC_HI:`B_ONOFF_TC_LO]); // R02
    case (env_cfg[`B_AMP_TC_HI:`B_AMP_TC_LO])
      2'h0:    next_cfg.amp_tc_ns = 14'd8400; // R03
      2'h1:    next_cfg.amp_tc_ns = 14'd6800; // R03
      2'h2:    next_cfg.amp_tc_ns = 14'd4400; // R03
      default: next_cfg.amp_tc_ns = 14'd2400; // R03
    endcase
    next_cfg.amp_thd_pct = env_cfg[`B_AMP_THD] ? 7'd95 : 7'd97; // R03
    next_cfg.bpsk = bpsk; // R14
    next_cfg.coll_from_slicer = iso_a106 && corr_a[`B_COLL_SRC]; // R05
    if (iso_a106)
    begin
      case (corr_a[`B_COLL_HI:`B_COLL_LO])
        2'h0:    next_cfg.coll_pct = 6'd16; // R11
        2'h1:    next_cfg.coll_pct = 6'd28; // R11
        2'h2:    next_cfg.coll_pct = 6'd41; // R11
        default: next_cfg.coll_pct = 6'd53; // R11
      endcase
    end
    next_cfg.phase_stop = bpsk && corr_a[`B_COLL_SRC]; // R06
    next_cfg.summation = corr_a[`B_SUM_EN]; // R08
    case ({corr_a[`B_START_LEN], rate_106_i})
      2'h0:    next_cfg.start_len = 6'd9; // R09
      2'h1:    next_cfg.start_len = 6'd17; // R09
      2'h2:    next_cfg.start_len = 6'd17; // R09
      default: next_cfg.start_len = 6'd33; // R09
    endcase
    next_cfg.fast_slicer = iso_a106 && corr_a[`B_FAST_SLICER]; // R10
    next_cfg.long_ref = bpsk && corr_a[`B_FAST_SLICER]; // R10
    if (bpsk)
      next_cfg.end_level_pct = corr_a[`B_COLL_HI] ? 7'd66 : 7'd100; // R12
    next_cfg.end_detect_en = bpsk && corr_a[`B_COLL_LO]; // R13
    next_cfg.stream_424 = corr_b[`B_STREAM_424]; // R17
    next_cfg.ref_offset_mv = corr_a[`B_REF_OFS] ? 8'd100 : 8'd50; // R18
    next_cfg.squelch_mv = corr_a[`B_REF_OFS] ? 8'd200 : 8'd100; // R18
  end

  // ***************************************************
  // Registered settings out
  // ***************************************************
  // Flopped so the analog side never sees decode glitches
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      cfg_o <= '0;
    else if (ce_i)
      cfg_o <= next_cfg;
  end

  // ***************************************************
  // AGC gain link
  // ***************************************************
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      gain_am_o <= 4'h0;
      gain_pm_o <= 4'h0;
    end
    else if (ce_i)
    begin
      if (corr_a[`B_AGC_LINK])
      begin
        gain_am_o <= (agc_am_i > agc_pm_i) ? agc_am_i : agc_pm_i; // R04
        gain_pm_o <= (agc_am_i > agc_pm_i) ? agc_am_i : agc_pm_i; // R04
      end
      else
      begin
        gain_am_o <= agc_am_i; // R04
        gain_pm_o <= agc_pm_i; // R04
      end
    end
  end

  // ***************************************************
  // Channel summation
  // ***************************************************
  // In summation mode channel B is unused and held at zero
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      dig_a_o <= 9'h000;
      dig_b_o <= 9'h000;
    end
    else if (ce_i)
    begin
      if (corr_a[`B_SUM_EN])
      begin
        dig_a_o <= {1'b0, corr_am_i} + {1'b0, corr_pm_i}; // R08
        dig_b_o <= 9'h000; // R08
      end
      else
      begin
        dig_a_o <= {1'b0, corr_am_i}; // R08
        dig_b_o <= {1'b0, corr_pm_i}; // R08
      end
    end
  end

  // ***************************************************
  // Correlator sleep control
  // ***************************************************
  // Stream V and 212 need the longer wake time
  assign wake_last = ((std_i == rx_corr_pkg::STD_V_STRM) || (std_i == rx_corr_pkg::STD_F212))
                     ? 12'(LongCyc - 1) : 12'(ShortCyc - 1); // R16

  // Idle timer restarts on every correlator pulse
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      state <= rx_corr_pkg::ST_AWAKE;
      cnt   <= 12'h000;
    end
    else if (ce_i)
    begin
      case (state)
        rx_corr_pkg::ST_AWAKE:
        begin
          if (pulse_i)
            cnt <= 12'h000;
          else if (cnt == 12'(IdleCyc - 1))
          begin
            state <= rx_corr_pkg::ST_SLEEP; // R15
            cnt   <= 12'h000;
          end
          else
            cnt <= cnt + 12'h001;
        end
        rx_corr_pkg::ST_SLEEP:
        begin
          if (corr_b[`B_WAKE_SEL])
          begin
            if (rx_on_i)
              state <= rx_corr_pkg::ST_AWAKE; // R15
          end
          else
            state <= rx_corr_pkg::ST_WAKING; // R15
          cnt <= 12'h000;
        end
        rx_corr_pkg::ST_WAKING:
        begin
          if (cnt >= wake_last)
          begin
            state <= rx_corr_pkg::ST_AWAKE; // R16
            cnt   <= 12'h000;
          end
          else
            cnt <= cnt + 12'h001;
        end
        default:
        begin
          state <= rx_corr_pkg::ST_AWAKE;
          cnt   <= 12'h000;
        end
      endcase
    end
  end

  // Sleep seen as active until wake completes
  assign sleep_o = (state != rx_corr_pkg::ST_AWAKE);

endmodule

// ---- rx_corr_map.svh ----
// Purpose: Map of the correlator config bank
// Assumes: Register index times four gives the Wishbone byte address
// Notes:   Definitions only
`ifndef RX_CORR_MAP_SVH
`define RX_CORR_MAP_SVH

// ***************************************************
// Register indices
// ***************************************************
`define IDX_ENV_CFG      6'h0b
`define IDX_CORR_A       6'h0c
`define IDX_CORR_B       6'h0d
`define IDX_STATUS       6'h20

// ***************************************************
// Reset values
// ***************************************************
`define RST_ENV_CFG      8'h0c
`define RST_CORR_A       8'h93
`define RST_CORR_B       2'h0

// ***************************************************
// Field positions
// ***************************************************
`define B_ONOFF_FD       7
`define B_ONOFF_TC_HI    6
`define B_ONOFF_TC_LO    5
`define B_ONOFF_THD_HI   4
`define B_ONOFF_THD_LO   3
`define B_AMP_TC_HI      2
`define B_AMP_TC_LO      1
`define B_AMP_THD        0
`define B_AGC_LINK       7
`define B_COLL_SRC       6
`define B_REF_OFS        5
`define B_SUM_EN         4
`define B_START_LEN      3
`define B_FAST_SLICER    2
`define B_COLL_HI        1
`define B_COLL_LO        0
`define B_WAKE_SEL       1
`define B_STREAM_424     0

// ***************************************************
// Timing
// ***************************************************
`define CLK_PERIOD_NS    20
`define SLEEP_IDLE_NS    18000
`define WAKE_SHORT_NS    18000
`define WAKE_LONG_NS     42000

`endif

// ---- rx_corr_pkg.sv ----
// Purpose: Types of the correlator config bank
// Assumes: Used by scoped name only
// Notes:   Decoded settings travel as one packed struct
package rx_corr_pkg;

  // ***************************************************
  // Receive standard in use
  // ***************************************************
  typedef enum logic [2:0]
  {
    STD_A_106  = 3'h0,
    STD_A_HBR  = 3'h1,
    STD_B      = 3'h2,
    STD_F212   = 3'h3,
    STD_F424   = 3'h4,
    STD_V_STRM = 3'h5,
    STD_S424   = 3'h6
  } std_e;

  // ***************************************************
  // Correlator sleep states
  // ***************************************************
  typedef enum logic [1:0]
  {
    ST_AWAKE  = 2'h0,
    ST_SLEEP  = 2'h1,
    ST_WAKING = 2'h2
  } sleep_e;

  // ***************************************************
  // Decoded settings for the analog receive path
  // ***************************************************
  typedef struct packed
  {
    logic [10:0] onoff_tc_ns;
    logic        onoff_fast_decay;
    logic [6:0]  onoff_thd_pct;
    logic [13:0] amp_tc_ns;
    logic [6:0]  amp_thd_pct;
    logic        bpsk;
    logic        coll_from_slicer;
    logic [5:0]  coll_pct;
    logic        phase_stop;
    logic        summation;
    logic [5:0]  start_len;
    logic        fast_slicer;
    logic        long_ref;
    logic [6:0]  end_level_pct;
    logic        end_detect_en;
    logic        stream_424;
    logic [7:0]  ref_offset_mv;
    logic [7:0]  squelch_mv;
  } rx_cfg_s;

endpackage

// ---- rx_corr_asserts.sv ----
// Purpose: Port checks of bus, gain, digitizer and sleep behaviour
// Assumes: One clock; ce_i may freeze the bank
// Notes:   Mirrors stored register bits from bus writes
`timescale 1ns/1ns

module rx_corr_asserts
(
  input wire logic              mclk_i,    // Clock
  input wire logic              nrst_i,    // Reset, low
  input wire logic              ce_i,      // Enable
  input wire logic              wb_cyc_i,  // Cycle
  input wire logic              wb_stb_i,  // Strobe
  input wire logic              wb_we_i,   // Write
  input wire logic [7:0]        wb_adr_i,  // Address
  input wire logic [3:0]        wb_sel_i,  // Lanes
  input wire logic [31:0]       wb_dat_i,  // Wdata
  input wire logic [31:0]       wb_dat_o,  // Rdata
  input wire logic              wb_ack_o,  // Ack
  input wire rx_corr_pkg::std_e std_i,     // Standard
  input wire logic              rx_on_i,   // Rx on
  input wire logic              pulse_i,   // Pulse
  input wire logic [3:0]        agc_am_i,  // AM AGC
  input wire logic [3:0]        agc_pm_i,  // PM AGC
  input wire logic [7:0]        corr_am_i, // AM sample
  input wire logic [7:0]        corr_pm_i, // PM sample
  input wire logic [3:0]        gain_am_o, // AM gain
  input wire logic [3:0]        gain_pm_o, // PM gain
  input wire logic [8:0]        dig_a_o,   // Dig A
  input wire logic [8:0]        dig_b_o,   // Dig B
  input wire logic              sleep_o    // Asleep
);
  logic [7:0]  sh_a;
  logic [1:0]  sh_b;
  logic [11:0] idle;
  logic [11:0] asleep;
  logic        take;
  logic        wr;
  logic        lng;
  logic [3:0]  mx;
  logic [3:0]  e_am;
  logic [3:0]  e_pm;
  logic [8:0]  e_da;
  logic [8:0]  e_db;

  // Expected gains and digitizer inputs
  assign take = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr   = ce_i && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign lng  = (std_i == rx_corr_pkg::STD_V_STRM) || (std_i == rx_corr_pkg::STD_F212);
  assign mx   = (agc_am_i > agc_pm_i) ? agc_am_i : agc_pm_i;
  assign e_am = sh_a[7] ? mx : agc_am_i;
  assign e_pm = sh_a[7] ? mx : agc_pm_i;
  assign e_da = sh_a[4] ? {1'b0, corr_am_i} + {1'b0, corr_pm_i} : {1'b0, corr_am_i};
  assign e_db = sh_a[4] ? 9'h000 : {1'b0, corr_pm_i};

  // Mirror of stored bits
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      sh_a <= 8'h93;
      sh_b <= 2'h0;
    end
    else if (wr && wb_adr_i[7:2] == 6'h0c)
      sh_a <= wb_dat_i[7:0];
    else if (wr && wb_adr_i[7:2] == 6'h0d)
      sh_b <= wb_dat_i[1:0];
  end

  // Quiet and asleep run lengths
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      idle   <= 12'h000;
      asleep <= 12'h000;
    end
    else if (ce_i)
    begin
      idle   <= (sleep_o || pulse_i) ? 12'h000 : idle + 12'h001;
      asleep <= sleep_o ? asleep + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  a_ack_after_req: assert property (take |=> wb_ack_o)
    else $error("no ack");
  a_ack_one_cycle: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("long ack");
  a_no_stray_ack: assert property (ce_i && !wb_stb_i |=> !wb_ack_o)
    else $error("stray ack");
  a_read_high_zero: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("upper bits");
  a_reserved_read_zero: assert property (
    take && !wb_we_i && wb_adr_i[7:2] == 6'h0d |=> wb_dat_o[7:0] == {6'h00, sh_b})
    else $error("reserved bits");
  a_agc_link_gain: assert property (
    ce_i |=> gain_am_o == $past(e_am) && gain_pm_o == $past(e_pm))
    else $error("gains");
  a_sum_digitize: assert property (
    ce_i |=> dig_a_o == $past(e_da) && dig_b_o == $past(e_db))
    else $error("digitizer");
  a_sleep_on_idle: assert property ($rose(sleep_o) |-> idle == 12'h384)
    else $error("early sleep");
  a_sleep_not_late: assert property (idle <= 12'h384)
    else $error("late sleep");
  a_wake_on_rx: assert property (sleep_o && sh_b[1] && rx_on_i && ce_i |=> !sleep_o)
    else $error("no rx wake");
  a_hold_for_rx: assert property (sleep_o && sh_b[1] && !rx_on_i && ce_i |=> sleep_o)
    else $error("early wake");
  a_wake_timer_len: assert property ($fell(sleep_o) && !sh_b[1] |->
    (lng ? (asleep >= 12'h833 && asleep <= 12'h837) : (asleep >= 12'h383 && asleep <= 12'h387)))
    else $error("wake length");

  c_sleep: cover property ($rose(sleep_o));
  c_rx_wake: cover property ($fell(sleep_o) && sh_b[1]);
  c_link_write: cover property (wr && wb_adr_i[7:2] == 6'h0c);
endmodule

bind rx_correlator_config_bank rx_corr_asserts rx_corr_asserts_inst (.*);

// ---- rx_corr_peer.sv ----
// Purpose: Remote peer model giving pulses, AGC results and samples
// Assumes: Pulses only while talk_i is high
// Notes:   Samples and PM AGC move every cycle; AM AGC every 16 cycles
`timescale 1ns/1ns

module rx_corr_peer
(
  input  wire logic  mclk_i,    // Clock
  input  wire logic  talk_i,    // Peer answering
  output logic       pulse_o,   // Correlator pulse
  output logic [3:0] agc_am_o,  // AM AGC
  output logic [3:0] agc_pm_o,  // PM AGC
  output logic [7:0] corr_am_o, // AM sample
  output logic [7:0] corr_pm_o  // PM sample
);
  logic [7:0] ph = 8'h00;

  // Phase steps every rising edge
  always @(posedge mclk_i)
    ph <= ph + 8'h01;

  // One pulse per four cycles
  assign pulse_o   = talk_i && (ph[1:0] == 2'h0);
  assign agc_am_o  = ph[7:4];
  assign agc_pm_o  = ph[3:0] ^ 4'h5;
  assign corr_am_o = ph;
  assign corr_pm_o = ~{ph[3:0], ph[7:4]};
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the correlator config bank
// Assumes: Bank acks one cycle after taking a request
// Notes:   Peer model feeds pulses and channel values
`timescale 1ns/1ns

module tb;
  logic                 mclk_i;
  logic                 nrst_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic                 rx_on = 1'b0, talk = 1'b1, rate = 1'b0, ack, slp, pulse;
  logic [7:0]           adr = 8'h00, cam, cpm;
  logic [3:0]           sel = 4'h0, am, pm, gam, gpm;
  logic [31:0]          wdat = 32'h0, rdat;
  logic [8:0]           da, db;
  rx_corr_pkg::std_e    std = rx_corr_pkg::STD_B;
  rx_corr_pkg::rx_cfg_s cfg;
  int                   err_count = 0, checks_done = 0, cyc_n = 0;

  rx_correlator_config_bank rx_correlator_config_bank_inst
  (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .std_i(std), .rate_106_i(rate), .rx_on_i(rx_on), .pulse_i(pulse),
    .agc_am_i(am), .agc_pm_i(pm), .corr_am_i(cam), .corr_pm_i(cpm), .cfg_o(cfg),
    .gain_am_o(gam), .gain_pm_o(gpm), .dig_a_o(da), .dig_b_o(db), .sleep_o(slp)
  );

  rx_corr_peer rx_corr_peer_inst
  (
    .mclk_i(mclk_i), .talk_i(talk), .pulse_o(pulse), .agc_am_o(am), .agc_pm_o(pm),
    .corr_am_o(cam), .corr_pm_o(cpm)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Hang guard, nearly three times the expected run
  always @(posedge mclk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      err_count = err_count + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Classic cycle: held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [7:0] q);
    @(posedge mclk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h000000, d};
    repeat (50)
      if (ack !== 1'b1)
        @(posedge mclk_i);
    q = rdat[7:0];
    chk("ack", ack, 1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, 4'hf, q);
    chk(nm, q, e);
  endtask

  task automatic t_regs;
    logic [7:0] q;
    rdchk("env rst", 8'h2c, 8'h0c);
    rdchk("corr_a rst", 8'h30, 8'h93);
    rdchk("corr_b rst", 8'h34, 8'h00);
    wr(8'h2c, 8'ha5);
    rdchk("env rw", 8'h2c, 8'ha5);
    wr(8'h34, 8'hff);
    rdchk("corr_b rsv", 8'h34, 8'h03);
    chk("stream", cfg.stream_424, 1);
    wb(1'b1, 8'h30, 8'h00, 4'he, q);
    rdchk("sel0", 8'h30, 8'h93);
    wr(8'h3c, 8'h55);
    rdchk("unmapped", 8'h3c, 8'h00);
    wr(8'h34, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_envelope;
    logic [10:0] tc[4] = '{11'h578, 11'h3e8, 11'h258, 11'h0c8};
    logic [6:0]  t0[4] = '{7'h37, 7'h2d, 7'h23, 7'h19};
    logic [6:0]  t1[4] = '{7'h50, 7'h4b, 7'h46, 7'h41};
    logic [13:0] at[4] = '{14'h20d0, 14'h1a90, 14'h1130, 14'h0960};
    logic [3:0]  i;
    for (int k = 0; k < 16; k++)
    begin
      i = k[3:0];
      wr(8'h2c, {i[0], i[3:2], i[1:0], i[1:0], i[3]});
      tick(2);
      chk("fd", cfg.onoff_fast_decay, i[0]);
      chk("ook tc", cfg.onoff_tc_ns, tc[i[3:2]]);
      chk("ook thd", cfg.onoff_thd_pct, i[3:2] == 2'h0 ? t0[i[1:0]] : t1[i[1:0]]);
      chk("ask tc", cfg.amp_tc_ns, at[i[1:0]]);
      chk("ask thd", cfg.amp_thd_pct, i[3] ? 7'h5f : 7'h61);
    end
    $display("t_envelope done");
  endtask

  // Every standard against low-bit patterns
  task automatic t_correlator;
    logic [5:0] cp[4] = '{6'h10, 6'h1c, 6'h29, 6'h35};
    logic [1:0] b;
    logic       a1, bp, rt;
    for (int k = 0; k < 28; k++)
    begin
      b = k[1:0];
      a1 = (k[4:2] == 3'h0);
      bp = (k[4:2] == 3'h1) || (k[4:2] == 3'h2);
      rt = b[0] ^ b[1];
      @(posedge mclk_i);
      std  <= rx_corr_pkg::std_e'(k[4:2]);
      rate <= rt;
      wr(8'h30, {1'b1, b[0], b[1], b[0], b[1], b[0], b});
      tick(2);
      chk("bpsk", cfg.bpsk, bp);
      chk("coll pct", cfg.coll_pct, a1 ? cp[b] : 6'h00);
      chk("fast slicer", cfg.fast_slicer, a1 & b[0]);
      chk("long ref", cfg.long_ref, bp & b[0]);
      chk("phase stop", cfg.phase_stop, bp & b[0]);
      chk("end level", cfg.end_level_pct, bp ? (b[1] ? 7'h42 : 7'h64) : 7'h00);
      chk("end det", cfg.end_detect_en, bp & b[0]);
      chk("sum", cfg.summation, b[0]);
      chk("start", cfg.start_len, rt ? (b[1] ? 6'h21 : 6'h11) : (b[1] ? 6'h11 : 6'h09));
      chk("ref ofs", {cfg.ref_offset_mv, cfg.squelch_mv}, b[1] ? 16'h64c8 : 16'h3264);
      if (a1)
        chk("coll src", cfg.coll_from_slicer, b[0]);
    end
    $display("t_correlator done");
  endtask

  task automatic t_gain_sum;
    wr(8'h30, 8'h80);
    tick(3);
    chk("linked", gam, gpm);
    wr(8'h30, 8'h10);
    tick(3);
    chk("summed b", db, 9'h000);
    wr(8'h30, 8'h00);
    tick(3);
    $display("t_gain_sum done");
  endtask

  // Silent peer; timer wake
  task automatic t_sleep_timer(input rx_corr_pkg::std_e s, input int lo);
    int n;
    n = 0;
    @(posedge mclk_i);
    std  <= s;
    talk <= 1'b0;
    repeat (1000)
      if (slp !== 1'b1)
        @(negedge mclk_i);
    chk("asleep", slp, 1);
    repeat (3000)
      if (slp === 1'b1)
      begin
        @(negedge mclk_i);
        n++;
      end
    chk("wake len", n >= lo && n <= lo + 5, 1);
    $display("t_sleep_timer done");
  endtask

  task automatic t_sleep_rx;
    logic [7:0] q;
    wr(8'h34, 8'h02);
    repeat (1000)
      if (slp !== 1'b1)
        @(negedge mclk_i);
    tick(1200);
    chk("held", slp, 1);
    wb(1'b0, 8'h80, 8'h00, 4'hf, q);
    chk("state", q[1:0], 2'h1);
    @(posedge mclk_i);
    rx_on <= 1'b1;
    tick(2);
    chk("rx wake", slp, 0);
    @(posedge mclk_i);
    rx_on <= 1'b0;
    talk  <= 1'b1;
    wr(8'h34, 8'h00);
    $display("t_sleep_rx done");
  endtask

  initial
  begin
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_envelope();
    t_correlator();
    t_gain_sum();
    t_sleep_timer(rx_corr_pkg::STD_B, 900);
    t_sleep_timer(rx_corr_pkg::STD_V_STRM, 2100);
    t_sleep_rx();
    tally_and_finish();
  end
endmodule
